/* design/clock_control_consts.svh */
// register map and timing figures of the clock control block
`ifndef CLOCK_CONTROL_CONSTS_SVH
`define CLOCK_CONTROL_CONSTS_SVH

`define OFS_OSCILLATOR_TRIM     8'h00
`define OFS_CLOCK_DIVIDER_CTL   8'h04
`define OFS_ASYNC_TIMER_STATUS  8'h08
`define OFS_CLOCK_STATUS        8'h0c

`define DIV_CHANGE_ENABLE_BIT   7
`define DIV_UNLOCK_VALUE        8'h80
`define DIV_SELECT_MAX          4'h8
`define DIV_SELECT_RESET        4'h0
`define DIV_SELECT_RESET_DIV8   4'h3
`define CHANGE_WINDOW_CYCLES    3'h4

`define TIMER_EXT_CLOCK_BIT     0
`define TRIM_PRE_LOAD           8'h00

`define SRC_EXTERNAL_CLOCK      4'h0
`define SRC_RC_OSCILLATOR       4'h2

`define STARTUP_FAST            2'h1
`define STARTUP_SLOW            2'h2

`define SYS_CLK_PERIOD_NS       25
`define RESET_BASE_CYCLES       14
`define WAKE_DELAY_CYCLES       6
`define STARTUP_FAST_DELAY_NS   4100000
`define STARTUP_SLOW_DELAY_NS   65000000
`define SETTLE_CYCLES           2'h3

`endif

/* design/clock_control_pkg.sv */
// types shared by the clock control block
package clock_control_pkg;

  typedef struct packed {
    logic [3:0] clock_source_select_fuses;
    logic [1:0] startup_time_fuses;
    logic       clock_output_fuse;
    logic       divide_by_eight_fuse;
  } fuse_type;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } bus_phase_type;

  typedef enum logic [1:0] {
    st_settle,
    st_load,
    st_delay,
    st_run
  } startup_state_type;

endpackage : clock_control_pkg

/* design/sync_two_flop.sv */
// two-flop synchroniser for pins and fuse levels
`timescale 1ns/1ps
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk_i,  // system clock
  input  wire logic             resetn_i,   // async reset, active low
  input  wire logic [WIDTH-1:0] async_i,    // level from another domain
  output logic      [WIDTH-1:0] sync_o      // synchronised level
);
  logic [WIDTH-1:0] first_stage;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      first_stage <= '0;
      sync_o      <= '0;
    end else begin
      first_stage <= async_i;
      sync_o      <= first_stage;
    end
  end

endmodule : sync_two_flop

/* design/prescale_divider.sv */
// power-of-two prescaler, switching at the end of a period
`timescale 1ns/1ps
`include "clock_control_consts.svh"
module prescale_divider (
  input  wire logic       sys_clk_i,        // undivided source clock
  input  wire logic       resetn_i,         // async reset, active low
  input  wire logic       load_i,           // one-cycle pulse: new select
  input  wire logic [3:0] select_i,         // new select code
  output logic            tick_o,           // one pulse per divided period
  output logic [3:0]      active_select_o   // select now in force
);
  logic [7:0] count;
  logic [3:0] pending;
  logic       pending_valid;
  logic [7:0] next_count;
  logic [3:0] next_pending;
  logic       next_pending_valid;
  logic [3:0] next_active;
  logic       next_tick;
  logic [7:0] last_count;

  always_comb begin
    last_count         = 8'((9'h001 << active_select_o) - 9'h001);
    next_pending       = pending;
    next_pending_valid = pending_valid;
    next_active        = active_select_o;
    next_tick          = 1'b0;
    next_count         = count + 8'h01;
    if (load_i) begin
      next_pending       = select_i;
      next_pending_valid = 1'b1;
    end
    // old period completes before the new code: no short pulse
    if (count == last_count) begin // see RULE8
      next_tick  = 1'b1;
      next_count = 8'h00;
      if (next_pending_valid) begin
        next_active        = next_pending; // see RULE9
        next_pending_valid = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count           <= 8'h00;
      pending         <= `DIV_SELECT_RESET;
      pending_valid   <= 1'b0;
      active_select_o <= `DIV_SELECT_RESET;
      tick_o          <= 1'b0;
    end else begin
      count           <= next_count;
      pending         <= next_pending;
      pending_valid   <= next_pending_valid;
      active_select_o <= next_active;
      tick_o          <= next_tick;
    end
  end

endmodule : prescale_divider

/* design/system_clock_prescaler_control.sv */
// clock source, start-up, clock output and prescaler over AHB-Lite
// Function
// RULE1: source fuses 0000 select the oscillator input pin.
// RULE2: start-up fuses pick 6 cycle wake, 14 cycles plus 0, 4.1ms or 65ms.
// RULE3: clock steps over 2% only while held in reset.
// RULE4: clock output fuse puts system clock on the pin, over the port.
// RULE5: the pin carries the prescaled clock; here the pin toggles once per prescaled period, at half that rate.
// RULE6: timer input takes an external clock only if enabled.
// RULE7: divide by 2^select for 0000..1000; higher codes reserved.
// RULE8: division switch makes no glitch nor shorter period.
// RULE9: new rate acts after old period plus one or two new.
// RULE10: unlock alone, then select within four cycles.
// RULE11: select is accepted only while change enable is set.
// RULE12: change enable updates only with other bits zero.
// RULE13: enable clears after four cycles or on select write; no restart.
// RULE14: interrupts stay off during unlock and write.
// RULE15: reset select is 0000, or 0011 with the divide-by-eight fuse programmed.
// RULE16: factory trim loads into the trim register during reset.
// RULE17: trim bit 7 picks the low or high overlapping range.
// RULE18: trim bits 6..0 tune monotonically within the range.
// RULE19: trim stays at or below 8.8MHz during memory writes.
// RULE20: source fuses 0010 select the internal RC oscillator.
// RULE21: divider control bits 6..4 read zero and ignore writes.
`timescale 1ns/1ps
`include "clock_control_consts.svh"
module system_clock_prescaler_control #(
  parameter int unsigned FAST_DELAY_CYCLES = `STARTUP_FAST_DELAY_NS / `SYS_CLK_PERIOD_NS,
  parameter int unsigned SLOW_DELAY_CYCLES = `STARTUP_SLOW_DELAY_NS / `SYS_CLK_PERIOD_NS
) (
  input  wire logic                       sys_clk_i,                    // undivided source clock
  input  wire logic                       resetn_i,                     // async reset, active low
  input  wire logic                       hsel_i,                       // AHB select
  input  wire logic [31:0]                haddr_i,                      // AHB address
  input  wire logic [1:0]                 htrans_i,                     // AHB transfer type
  input  wire logic                       hwrite_i,                     // AHB write
  input  wire logic [2:0]                 hsize_i,                      // AHB size
  input  wire logic [31:0]                hwdata_i,                     // AHB write data
  input  wire logic                       hready_i,                     // AHB ready in
  output logic      [31:0]                hrdata_o,                     // AHB read data
  output logic                            hreadyout_o,                  // AHB ready out
  output logic                            hresp_o,                      // AHB response, OKAY
  input  wire clock_control_pkg::fuse_type fuses_i,                     // fuse levels
  input  wire logic [7:0]                 factory_trim_i,               // factory trim byte
  input  wire logic                       oscillator_input_pin_i,       // external clock pin
  input  wire logic                       timer_oscillator_input_pin_i, // timer oscillator pin
  input  wire logic                       port_data_i,                  // normal port value
  input  wire logic                       port_oe_i,                    // normal port enable
  input  wire logic                       wake_request_i,               // pulse: leave sleep
  output logic                            use_external_clock_o,         // source is the pin
  output logic                            use_rc_oscillator_o,          // source is RC osc
  output logic                            external_clock_o,             // sampled pin clock
  output logic                            cpu_clock_enable_o,           // one pulse per period
  output logic                            clock_output_pin_o,           // clock output pin
  output logic                            clock_output_pin_oe_o,        // its output enable
  output logic                            core_release_o,               // start-up done
  output logic                            wake_ready_o,                 // wake delay done
  output logic      [7:0]                 oscillator_trim_o,            // trim to RC osc
  output logic                            timer_external_clock_o,       // timer uses ext clock
  output logic                            timer_clock_o                 // sampled timer clock
);
  import clock_control_pkg::*;

  fuse_type          fuse_sync;
  fuse_type          fuse_latched;
  fuse_type          next_fuse_latched;
  logic [1:0]        pin_sync;
  startup_state_type state;
  startup_state_type next_state;
  logic [23:0]       delay_count;
  logic [23:0]       next_delay_count;
  logic [1:0]        settle_count;
  logic [1:0]        next_settle_count;
  logic [2:0]        wake_count;
  logic [2:0]        next_wake_count;
  logic              next_core_release;
  logic              next_wake_ready;
  bus_phase_type     data_phase;
  bus_phase_type     next_data_phase;
  logic [7:0]        next_trim;
  logic [3:0]        divider_select;
  logic [3:0]        next_divider_select;
  logic              change_enable;
  logic              next_change_enable;
  logic [2:0]        change_timer;
  logic [2:0]        next_change_timer;
  logic              timer_ext;
  logic              next_timer_ext;
  logic [31:0]       next_rdata;
  logic              div_load;
  logic [3:0]        active_select;
  logic              divider_tick;
  logic              divided_level;
  logic              next_divided_level;
  logic [7:0]        wbyte;
  logic              next_use_ext;
  logic              next_use_rc;
  logic              next_ext_clock;
  logic              next_pin;
  logic              next_pin_oe;
  logic              next_timer_clock;
  logic              load_select;
  logic [3:0]        load_value;

  sync_two_flop #(.WIDTH($bits(fuse_type))) u_fuse_sync (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .async_i   (fuses_i),
    .sync_o    (fuse_sync)
  );

  sync_two_flop #(.WIDTH(2)) u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .async_i   ({timer_oscillator_input_pin_i, oscillator_input_pin_i}),
    .sync_o    (pin_sync)
  );

  prescale_divider u_divider (
    .sys_clk_i       (sys_clk_i),
    .resetn_i        (resetn_i),
    .load_i          (div_load),
    .select_i        (load_value),
    .tick_o          (divider_tick),
    .active_select_o (active_select)
  );

  // start-up: fuses settle, then load
  always_comb begin
    next_state        = state;
    next_settle_count = settle_count;
    next_delay_count  = delay_count;
    next_fuse_latched = fuse_latched;
    next_core_release = core_release_o;
    next_wake_count   = wake_count;
    next_wake_ready   = 1'b0;
    case (state)
      st_settle: begin
        next_settle_count = settle_count + 2'h1;
        if (settle_count == `SETTLE_CYCLES) begin
          next_state = st_load;
        end
      end
      st_load: begin
        next_fuse_latched = fuse_sync;
        next_delay_count  = 24'(`RESET_BASE_CYCLES); // see RULE2
        // reserved start-up code falls back to the longest delay
        if (fuse_sync.startup_time_fuses == `STARTUP_FAST) begin
          next_delay_count = 24'(`RESET_BASE_CYCLES + FAST_DELAY_CYCLES);
        end else if (fuse_sync.startup_time_fuses != 2'h0) begin
          next_delay_count = 24'(`RESET_BASE_CYCLES + SLOW_DELAY_CYCLES);
        end
        next_state = st_delay;
      end
      st_delay: begin
        next_delay_count = delay_count - 24'h000001;
        if (delay_count == 24'h000001) begin
          next_core_release = 1'b1;
          next_state        = st_run;
        end
      end
      st_run: begin
        if (wake_request_i) begin
          next_wake_count = 3'(`WAKE_DELAY_CYCLES); // see RULE2
        end else if (wake_count != 3'h0) begin
          next_wake_count = wake_count - 3'h1;
          next_wake_ready = (wake_count == 3'h1);
        end
      end
      default: begin
        next_state = st_settle;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state          <= st_settle;
      settle_count   <= 2'h0;
      delay_count    <= 24'h000000;
      fuse_latched   <= '0;
      core_release_o <= 1'b0;
      wake_count     <= 3'h0;
      wake_ready_o   <= 1'b0;
    end else begin
      state          <= next_state;
      settle_count   <= next_settle_count;
      delay_count    <= next_delay_count;
      fuse_latched   <= next_fuse_latched;
      core_release_o <= next_core_release;
      wake_count     <= next_wake_count;
      wake_ready_o   <= next_wake_ready;
    end
  end

  // registers and AHB-Lite slave: zero wait, always OKAY
  always_comb begin
    next_data_phase.valid = hsel_i & hready_i & htrans_i[1];
    next_data_phase.write = hwrite_i;
    next_data_phase.addr  = haddr_i[7:0];
    wbyte                 = hwdata_i[7:0];
    next_trim             = oscillator_trim_o;
    next_divider_select   = divider_select;
    next_change_enable    = change_enable;
    next_change_timer     = change_timer;
    next_timer_ext        = timer_ext;
    load_select           = 1'b0;
    load_value            = divider_select;
    if (change_enable) begin
      next_change_timer = change_timer - 3'h1;
      if (change_timer == 3'h1) begin
        next_change_enable = 1'b0; // see RULE13
      end
    end
    if (state == st_load) begin
      next_trim           = factory_trim_i; // see RULE16
      next_divider_select = fuse_sync.divide_by_eight_fuse ? `DIV_SELECT_RESET_DIV8
                                                           : `DIV_SELECT_RESET; // see RULE15
      load_select         = 1'b1;
      load_value          = next_divider_select;
    end else if (data_phase.valid && data_phase.write) begin
      case (data_phase.addr)
        `OFS_OSCILLATOR_TRIM: begin
          next_trim = wbyte; // see RULE17
        end
        `OFS_CLOCK_DIVIDER_CTL: begin
          // unlock rewrite inside the window is ignored
          if (wbyte == `DIV_UNLOCK_VALUE) begin // see RULE12
            if (!change_enable) begin
              next_change_enable = 1'b1;
              next_change_timer  = `CHANGE_WINDOW_CYCLES; // see RULE13
            end
          end else if (!wbyte[`DIV_CHANGE_ENABLE_BIT] && change_enable) begin // see RULE11
            next_change_enable = 1'b0; // see RULE13
            // reserved codes keep the current division
            if (wbyte[3:0] <= `DIV_SELECT_MAX) begin // see RULE7
              next_divider_select = wbyte[3:0];
              load_select         = 1'b1;
              load_value          = wbyte[3:0];
            end
          end
        end
        `OFS_ASYNC_TIMER_STATUS: begin
          next_timer_ext = wbyte[`TIMER_EXT_CLOCK_BIT];
        end
        default: begin
        end
      endcase
    end
    // read from next values, status from current ones: read after write sees it
    next_rdata = 32'h00000000;
    if (next_data_phase.valid && !next_data_phase.write) begin
      case (next_data_phase.addr)
        `OFS_OSCILLATOR_TRIM:    next_rdata = {24'h000000, next_trim};
        `OFS_CLOCK_DIVIDER_CTL:  next_rdata = {24'h000000, next_change_enable, 3'h0,
                                               next_divider_select}; // see RULE21
        `OFS_ASYNC_TIMER_STATUS: next_rdata = {31'h00000000, next_timer_ext};
        `OFS_CLOCK_STATUS:       next_rdata = {24'h000000, use_rc_oscillator_o, use_external_clock_o,
                                               core_release_o, 1'b0, active_select};
        default:                 next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_phase        <= '0;
      hrdata_o          <= 32'h00000000;
      hreadyout_o       <= 1'b1;
      hresp_o           <= 1'b0;
      oscillator_trim_o <= `TRIM_PRE_LOAD;
      divider_select    <= `DIV_SELECT_RESET;
      change_enable     <= 1'b0;
      change_timer      <= 3'h0;
      timer_ext         <= 1'b0;
      div_load          <= 1'b0;
    end else begin
      data_phase        <= next_data_phase;
      hrdata_o          <= next_rdata;
      hreadyout_o       <= 1'b1;
      hresp_o           <= 1'b0;
      oscillator_trim_o <= next_trim; // see RULE18
      divider_select    <= next_divider_select;
      change_enable     <= next_change_enable;
      change_timer      <= next_change_timer;
      timer_ext         <= next_timer_ext;
      div_load          <= load_select;
    end
  end

  // clock source, output pin and timer input steering
  always_comb begin
    next_use_ext       = (fuse_latched.clock_source_select_fuses == `SRC_EXTERNAL_CLOCK); // see RULE1
    next_use_rc        = (fuse_latched.clock_source_select_fuses == `SRC_RC_OSCILLATOR); // see RULE20
    next_ext_clock     = next_use_ext & pin_sync[0];
    next_divided_level = divider_tick ? ~divided_level : divided_level;
    // fuse taken live: pin claimed once it settles
    if (fuse_sync.clock_output_fuse) begin
      next_pin    = next_divided_level; // see RULE5
      next_pin_oe = 1'b1; // see RULE4
    end else begin
      next_pin    = port_data_i;
      next_pin_oe = port_oe_i;
    end
    next_timer_clock = timer_ext & pin_sync[1]; // see RULE6
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      use_external_clock_o   <= 1'b0;
      use_rc_oscillator_o    <= 1'b0;
      external_clock_o       <= 1'b0;
      divided_level          <= 1'b0;
      cpu_clock_enable_o     <= 1'b0;
      clock_output_pin_o     <= 1'b0;
      clock_output_pin_oe_o  <= 1'b0;
      timer_external_clock_o <= 1'b0;
      timer_clock_o          <= 1'b0;
    end else begin
      use_external_clock_o   <= next_use_ext;
      use_rc_oscillator_o    <= next_use_rc;
      external_clock_o       <= next_ext_clock;
      divided_level          <= next_divided_level;
      cpu_clock_enable_o     <= divider_tick; // see RULE7
      clock_output_pin_o     <= next_pin;
      clock_output_pin_oe_o  <= next_pin_oe;
      timer_external_clock_o <= timer_ext;
      timer_clock_o          <= next_timer_clock;
    end
  end

endmodule : system_clock_prescaler_control

/* dv/ext_clock_source.sv */
// free-running clock source for the oscillator and timer pins
`timescale 1ns/1ps
module ext_clock_source #(
  parameter real OSC_HALF   = 37.0,
  parameter real TIMER_HALF = 61.0
) (
  output logic osc_pin_o,  // oscillator input pin
  output logic timer_pin_o // timer oscillator pin
);
  initial osc_pin_o = 1'b0;
  initial timer_pin_o = 1'b0;
  // fixed half periods: no drift
  always #(OSC_HALF) osc_pin_o = ~osc_pin_o;
  always #(TIMER_HALF) timer_pin_o = ~timer_pin_o;
endmodule : ext_clock_source

/* dv/system_clock_prescaler_control_asserts.sv */
// port checker for the clock control block
`timescale 1ns/1ps
`include "clock_control_consts.svh"
module system_clock_prescaler_control_asserts (
  input wire logic                        sys_clk_i,              // clock
  input wire logic                        resetn_i,               // reset, active low
  input wire clock_control_pkg::fuse_type fuses_i,                // fuses
  input wire logic [7:0]                  factory_trim_i,         // factory trim
  input wire logic                        port_data_i,            // port value
  input wire logic                        port_oe_i,              // port enable
  input wire logic                        wake_request_i,         // wake pulse
  input wire logic                        use_external_clock_o,   // source pin
  input wire logic                        use_rc_oscillator_o,    // source rc
  input wire logic                        external_clock_o,       // pin clock
  input wire logic                        cpu_clock_enable_o,     // divided tick
  input wire logic                        clock_output_pin_o,     // output pin
  input wire logic                        clock_output_pin_oe_o,  // pin enable
  input wire logic                        core_release_o,         // start-up done
  input wire logic                        wake_ready_o,           // wake done
  input wire logic [7:0]                  oscillator_trim_o,      // trim
  input wire logic                        timer_external_clock_o, // timer enable
  input wire logic                        timer_clock_o           // timer clock
);
  logic [8:0] gap_cnt;
  logic [8:0] next_gap_cnt;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  always_comb next_gap_cnt = cpu_clock_enable_o ? 9'h000 : gap_cnt + 9'h001;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) gap_cnt <= 9'h000;
    else gap_cnt <= next_gap_cnt;
  end
  // fuse passes a synchroniser: hold it five cycles
  sequence fuse_on;  fuses_i.clock_output_fuse [*5]; endsequence
  sequence fuse_off; !fuses_i.clock_output_fuse [*5]; endsequence
  sequence woke;     wake_request_i && core_release_o; endsequence
  AST_EXT_GATE: assert property (!use_external_clock_o |-> !external_clock_o)
    else $error("pin clock leaked");
  AST_SRC_DECODE: assert property (core_release_o |-> use_external_clock_o ==
    (fuses_i.clock_source_select_fuses == `SRC_EXTERNAL_CLOCK) &&
    use_rc_oscillator_o == (fuses_i.clock_source_select_fuses == `SRC_RC_OSCILLATOR))
    else $error("bad source select");
  AST_CLKOUT_EN: assert property (fuse_on |-> clock_output_pin_oe_o)
    else $error("clock pin not driven");
  AST_PORT_PASS: assert property (fuse_off |-> clock_output_pin_oe_o == $past(port_oe_i) &&
    clock_output_pin_o == $past(port_data_i))
    else $error("port function lost");
  AST_TIMER_GATE: assert property (!timer_external_clock_o [*2] |-> !timer_clock_o)
    else $error("timer clock leaked");
  AST_RELEASE_HOLD: assert property (core_release_o |=> core_release_o)
    else $error("start-up release dropped");
  AST_WAKE_DELAY: assert property (woke |-> ##[6:7] wake_ready_o)
    else $error("wake delay not met");
  AST_WAKE_CAUSE: assert property (wake_ready_o |-> $past(wake_request_i, 6) || $past(wake_request_i, 7))
    else $error("wake ready without request");
  AST_TRIM_LOAD: assert property ($rose(core_release_o) |-> oscillator_trim_o == factory_trim_i)
    else $error("factory trim not loaded");
  AST_DIV_GAP: assert property (gap_cnt < 9'h100)
    else $error("divided tick too slow");
endmodule : system_clock_prescaler_control_asserts

bind system_clock_prescaler_control system_clock_prescaler_control_asserts u_asserts (.*);

/* dv/system_clock_prescaler_control_tb_top.sv */
// self-checking bench for the clock control block
`timescale 1ns/1ps
`include "clock_control_consts.svh"
module system_clock_prescaler_control_tb_top;
  import clock_control_pkg::*;
  typedef struct packed { logic [7:0] addr; logic [31:0] data; } note_type;
  logic        sys_clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        hsel = 1'b0, hwrite, rd_dp, wake_req = 1'b0, port_data, port_oe;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [7:0]  factory_trim, trim_o;
  logic        hready, hresp, osc_pin, tmr_pin, clk_en, pin_o, pin_oe, release_o, tmr_ext;
  fuse_type    fuses;
  note_type    notes[$];
  int          failures = 0, check_count = 0, cyc = 0;
  localparam logic [7:0] CTL = `OFS_CLOCK_DIVIDER_CTL;

  always #12.5 sys_clk_i = ~sys_clk_i;
  ext_clock_source src (.osc_pin_o(osc_pin), .timer_pin_o(tmr_pin));
  system_clock_prescaler_control #(.FAST_DELAY_CYCLES(20), .SLOW_DELAY_CYCLES(40)) dut (
    .sys_clk_i, .resetn_i, .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .fuses_i(fuses), .factory_trim_i(factory_trim), .oscillator_input_pin_i(osc_pin),
    .timer_oscillator_input_pin_i(tmr_pin), .port_data_i(port_data), .port_oe_i(port_oe),
    .wake_request_i(wake_req), .use_external_clock_o(), .use_rc_oscillator_o(), .external_clock_o(),
    .cpu_clock_enable_o(clk_en), .clock_output_pin_o(pin_o), .clock_output_pin_oe_o(pin_oe),
    .core_release_o(release_o), .wake_ready_o(), .oscillator_trim_o(trim_o),
    .timer_external_clock_o(tmr_ext), .timer_clock_o());

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  // reads: d is the expected word
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    if (!wr) notes.push_back('{a, d});
    do @(posedge sys_clk_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= !wr;
    do @(posedge sys_clk_i); while (hready !== 1'b1);
    rd_dp <= 1'b0;
  endtask : xfer

  task automatic set_div(input logic [31:0] s);
    xfer(1'b1, CTL, {24'h0, `DIV_UNLOCK_VALUE});
    xfer(1'b1, CTL, s);
  endtask : set_div

  // last of four gaps: a switch in flight is skipped
  task automatic gap(input logic p, input logic [31:0] e, input string nm);
    int   n;
    logic l;
    for (int k = 0; k < 4; k++) begin
      n = 0;
      l = pin_o;
      do begin
        @(posedge sys_clk_i);
        n++;
      end while (!(p ? pin_o !== l : clk_en === 1'b1) && n < 600);
    end
    check(nm, 32'(n), e);
  endtask : gap

  always @(posedge sys_clk_i) begin
    if (rd_dp === 1'b1) begin
      check($sformatf("read %h", notes[0].addr), hrdata, notes[0].data);
      check("hresp", {31'h0, hresp}, 32'h0);
      void'(notes.pop_front());
    end
  end
  always @(posedge sys_clk_i) begin
    port_data <= 1'($urandom);
    port_oe <= 1'($urandom);
  end
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      end_sim();
    end
  end

  initial begin
    void'($urandom(44));
    factory_trim = 8'($urandom);
    fuses = '{4'h0, 2'h1, 1'b0, 1'b1};
    repeat (8) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    do @(posedge sys_clk_i); while (release_o !== 1'b1);
    xfer(1'b0, `OFS_CLOCK_STATUS, 32'h63);
    xfer(1'b0, `OFS_OSCILLATOR_TRIM, {24'h0, factory_trim});
    xfer(1'b0, CTL, 32'h03);
    gap(1'b0, 32'h8, "reset period");
    for (int s = 0; s <= 8; s++) begin
      set_div(s);
      xfer(1'b0, CTL, s);
      gap(1'b0, 32'h1 << s, "cpu period");
      xfer(1'b0, `OFS_CLOCK_STATUS, 32'h60 | s);
    end
    set_div(32'(9 + $urandom_range(6)));
    xfer(1'b0, CTL, 32'h08);
    xfer(1'b1, CTL, 32'h05);
    xfer(1'b0, CTL, 32'h08);
    xfer(1'b1, CTL, 32'h85);
    xfer(1'b1, CTL, 32'h01);
    xfer(1'b0, CTL, 32'h08);
    xfer(1'b1, CTL, 32'h80);
    xfer(1'b0, CTL, 32'h88);
    repeat (4) @(posedge sys_clk_i);
    xfer(1'b1, CTL, 32'h02);
    xfer(1'b0, CTL, 32'h08);
    xfer(1'b1, CTL, 32'h80);
    xfer(1'b1, CTL, 32'h80);
    repeat (2) @(posedge sys_clk_i);
    xfer(1'b0, CTL, 32'h08);
    set_div(32'h72);
    xfer(1'b0, CTL, 32'h02);
    r = {24'h0, 8'($urandom)};
    xfer(1'b1, `OFS_OSCILLATOR_TRIM, r);
    xfer(1'b0, `OFS_OSCILLATOR_TRIM, r);
    check("trim out", {24'h0, trim_o}, r);
    xfer(1'b1, `OFS_ASYNC_TIMER_STATUS, 32'h1);
    xfer(1'b0, `OFS_ASYNC_TIMER_STATUS, 32'h1);
    check("timer enable", {31'h0, tmr_ext}, 32'h1);
    repeat (20) @(posedge sys_clk_i);
    xfer(1'b1, `OFS_ASYNC_TIMER_STATUS, 32'h0);
    xfer(1'b1, 8'h10, 32'hff);
    xfer(1'b0, 8'h10, 32'h0);
    wake_req <= 1'b1;
    @(posedge sys_clk_i);
    wake_req <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    fuses.clock_output_fuse <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    check("pin enable", {31'h0, pin_oe}, 32'h1);
    gap(1'b1, 32'h4, "pin half period");
    end_sim();
  end
endmodule : system_clock_prescaler_control_tb_top
